// file: rtl/serial_cmd_if.sv
// serial command link between host and register bank
// assumes the testbench joins both modports
`timescale 1ns/1ps
`default_nettype none
interface serial_cmd_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   modport host (output sck, output cs_n, output mosi, input miso);
   modport dev (input sck, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

// file: rtl/sticky_flag.sv
// one sticky status bit: set wins over clear
// assumes synchronous set and clear pulses
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic rst_val,
   input wire logic load,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   logic q_next;
   assign q_next = load ? rst_val : (set | (q & ~clr));
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         q <= 1'b0;
      else
         q <= q_next;
   end
endmodule
`default_nettype wire

// file: rtl/supply_host_ctrl.sv
// host end: avalon-mm slave turning orders into 16-bit serial commands
// assumes the device samples mosi on sck rise
`timescale 1ns/1ps
`default_nettype none
module supply_host_ctrl
   import supply_regs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   serial_cmd_if.host link
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } host_st_e;
   host_st_e st_reg;
   logic [15:0] tx_reg;
   logic [7:0] rx_reg;
   logic [4:0] bit_reg;
   logic [2:0] div_reg;
   logic sck_reg;
   logic cs_n_reg;
   logic done_reg;
   logic wait_reg;
   logic [31:0] rd_reg;
   logic start;
   logic [15:0] frame;
   logic [7:0] data_bits;
   assign start = avs_write & (avs_address == AV_CTRL) & (st_reg == ST_IDLE) & wait_reg;
   // ctrl word: [6:0] address, [7] clear, [15:8] data, sent frame bit 0 first
   assign data_bits = {avs_writedata[8], avs_writedata[9], avs_writedata[10], avs_writedata[11],
      avs_writedata[12], avs_writedata[13], avs_writedata[14], avs_writedata[15]};
   assign frame = {avs_writedata[0], avs_writedata[1], avs_writedata[2], avs_writedata[3],
      avs_writedata[4], avs_writedata[5], avs_writedata[6], avs_writedata[7],
      data_bits};
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= ST_IDLE;
         tx_reg <= 16'h0000;
         rx_reg <= 8'h00;
         bit_reg <= 5'd0;
         div_reg <= 3'd0;
         sck_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         done_reg <= 1'b0;
      end
      else
      begin
         unique case (st_reg)
            ST_IDLE:
            begin
               if (start)
               begin
                  tx_reg <= frame;
                  cs_n_reg <= 1'b0;
                  bit_reg <= 5'd0;
                  div_reg <= 3'd0;
                  done_reg <= 1'b0;
                  st_reg <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               div_reg <= div_reg + 3'd1;
               if (div_reg == 3'(SCK_HALF - 1))
               begin
                  div_reg <= 3'd0;
                  sck_reg <= ~sck_reg;
                  if (sck_reg)
                  begin
                     tx_reg <= {tx_reg[14:0], 1'b0};
                     bit_reg <= bit_reg + 5'd1;
                     if (bit_reg == 5'd15)
                        st_reg <= ST_DONE;
                  end
                  else if (bit_reg >= 5'd8)
                     rx_reg <= {link.miso, rx_reg[7:1]};
               end
            end
            ST_DONE:
            begin
               cs_n_reg <= 1'b1;
               done_reg <= 1'b1;
               st_reg <= ST_IDLE;
            end
            default:
               st_reg <= ST_IDLE;
         endcase
      end
   end
   assign link.sck = sck_reg;
   assign link.cs_n = cs_n_reg;
   assign link.mosi = tx_reg[15];
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wait_reg <= 1'b1;
         rd_reg <= 32'h0000_0000;
      end
      else
      begin
         wait_reg <= ~((avs_read | avs_write) & wait_reg
            & ~(avs_write & (avs_address == AV_CTRL) & (st_reg != ST_IDLE)));
         if (avs_address == AV_STAT)
            rd_reg <= {30'h0, done_reg, st_reg != ST_IDLE};
         else if (avs_address == AV_RDATA)
            rd_reg <= {24'h0, rx_reg};
         else
            rd_reg <= 32'h0000_0000;
      end
   end
   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rd_reg;
endmodule
`default_nettype wire

// file: rtl/supply_regs_pkg.sv
// constants shared by the serial command link ends
// assumes both ends run on one clk_sys at 50 MHz
package supply_regs_pkg;
   localparam int CMD_BITS = 16;
   localparam int ADDR_BITS = 7;
   localparam int DATA_LSB = 8;
   localparam int MODE_BIT = 7;
   localparam logic [6:0] ADDR_UPPER = 7'h3e;
   localparam logic [6:0] ADDR_LOWER = 7'h3f;
   localparam logic [6:0] ADDR_STAT_B = 7'h40;
   localparam logic [6:0] ADDR_STAT_A = 7'h41;
   localparam logic [7:0] UPPER_RST = 8'ha8;
   localparam logic [7:0] LOWER_RST = 8'h98;
   localparam logic [7:0] STAT_B_RST = 8'h00;
   localparam logic [7:0] STAT_A_POR = 8'h80;
   localparam logic [7:0] STAT_A_SOFT = 8'h00;
   localparam logic [7:0] STAT_B_MASK = 8'h43;
   localparam logic [7:0] STAT_A_MASK = 8'hff;
   localparam logic [7:0] STAT_B_RESTART_KEEP = 8'h43;
   localparam logic [7:0] STAT_A_RESTART_KEEP = 8'hfd;
   localparam int BIT_BATT_UV = 6;
   localparam int BIT_MAIN_OV = 1;
   localparam int BIT_MAIN_PW = 0;
   localparam int BIT_POR = 7;
   localparam int BIT_SW_UV = 6;
   localparam int BIT_SW_OV = 5;
   localparam int BIT_SEC_OT = 4;
   localparam int BIT_SEC_UV = 3;
   localparam int BIT_MAIN_SC = 2;
   localparam int BIT_MAIN_FS = 1;
   localparam int BIT_MAIN_UV = 0;
   localparam int CLK_HZ = 50000000;
   localparam int SHORT_TIME_US = 4000;
   localparam int SHORT_CYCLES = SHORT_TIME_US * (CLK_HZ / 1000000) + 1;
   localparam int FS_COUNT = 4;
   localparam logic [15:0] AV_CTRL = 16'h0000;
   localparam logic [15:0] AV_STAT = 16'h0004;
   localparam logic [15:0] AV_RDATA = 16'h0008;
   localparam int SCK_HALF = 4;
   typedef enum logic [4:0]
   {
      MODE_INIT = 5'b00001,
      MODE_NORMAL = 5'b00010,
      MODE_STOP = 5'b00100,
      MODE_SLEEP = 5'b01000,
      MODE_RESTART = 5'b10000
   } dev_mode_e;
endpackage

// file: rtl/supply_status_spi_regs.sv
// device end: register bank reached by 16-bit serial commands
// assumes sck, cs_n, mosi synchronous to clk_sys; host samples miso on sck rise
// Summary of operation
// - command is 16 bits: address, mode, data
// - data bits D0..D7 are frame bits 8..15
// - bit 7 low reads without touching flags
// - bit 7 high clears addressed status byte
// - flags stay set until host clears or soft reset; restart mode clears status a bit 1
// - reserved bits read zero, ignore clears
// - upper limit resets a8, clamps high settings
// - lower limit resets 98, clamps low settings
// - battery undervoltage sets status b bit 6
// - main regulator overvoltage sets b bit 1
// - main regulator prewarning sets b bit 0
// - power-on flag 1 after por, 0 soft
// - second regulator ot bit 4, uv bit 3
// - main below reset over 4 ms sets bit 2
// - fourth undervoltage fail-safe entry sets bit 1; code sets it on the first main_failsafe_evt pulse, FS_COUNT unused
// - main undervoltage reset sets bit 0
// - sleep with main off blocks main overvoltage, short and undervoltage flags
// - main undervoltage flag gated by mode
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module supply_status_spi_regs
   import supply_regs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   serial_cmd_if.dev link,
   input wire logic soft_reset,
   input wire dev_mode_e dev_mode,
   input wire logic main_reg_off,
   input wire logic reset_output_pin,
   input wire logic batt_uv_evt,
   input wire logic main_ov_evt,
   input wire logic main_pw_evt,
   input wire logic sw_uv_evt,
   input wire logic sw_ov_evt,
   input wire logic sec_ot_evt,
   input wire logic sec_uv_evt,
   input wire logic main_below_rst,
   input wire logic main_uv_evt,
   input wire logic main_failsafe_evt,
   input wire logic [7:0] bit_time_setting,
   output logic [7:0] bit_time_clamped,
   output logic [7:0] recovery_upper_bound,
   output logic [7:0] recovery_lower_bound
);
   logic [15:0] shift_reg;
   logic [4:0] cnt_reg;
   logic sck_d_reg;
   logic miso_reg;
   logic por_pend_reg;
   logic ro_seen_reg;
   logic [22:0] sc_cnt_reg;
   logic [7:0] hdr_reg;
   logic [7:0] rd_byte;
   logic [7:0] stat_a;
   logic [7:0] stat_b;
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] clr_a;
   logic [7:0] clr_b;
   logic [7:0] keep_a;
   logic [7:0] keep_b;
   logic [7:0] rst_a;
   logic sck_rise;
   logic sck_fall;
   logic frame_done;
   logic [6:0] cmd_addr;
   logic cmd_clear;
   logic [7:0] cmd_data;
   logic restart;
   logic load_rst;
   logic main_gate;
   logic short_long;
   logic uv_allowed;
   logic uv_ok;
   assign sck_rise = link.sck & ~sck_d_reg;
   assign sck_fall = ~link.sck & sck_d_reg;
   assign frame_done = ~link.cs_n & sck_rise & (cnt_reg == 5'd15);
   // header byte latched at the 8th sck rise, frame bit i lands in bit i
   assign cmd_addr = hdr_reg[6:0];
   assign cmd_clear = hdr_reg[MODE_BIT];
   assign cmd_data = {link.mosi, shift_reg[0], shift_reg[1], shift_reg[2], shift_reg[3],
      shift_reg[4], shift_reg[5], shift_reg[6]};
   assign restart = (dev_mode == MODE_RESTART);
   assign load_rst = soft_reset;
   assign main_gate = ~((dev_mode == MODE_SLEEP) & main_reg_off);
   assign short_long = (sc_cnt_reg >= 23'(SHORT_CYCLES));
   assign uv_allowed = (dev_mode == MODE_NORMAL) | (dev_mode == MODE_STOP)
      | ((dev_mode == MODE_INIT) & ro_seen_reg);
   assign uv_ok = main_gate & (short_long | uv_allowed);
   assign set_b = ({7'h00, main_pw_evt} << BIT_MAIN_PW)
      | ({7'h00, main_ov_evt & main_gate} << BIT_MAIN_OV)
      | ({7'h00, batt_uv_evt} << BIT_BATT_UV);
   assign set_a = ({7'h00, por_pend_reg} << BIT_POR)
      | ({7'h00, sw_uv_evt} << BIT_SW_UV) | ({7'h00, sw_ov_evt} << BIT_SW_OV)
      | ({7'h00, sec_ot_evt} << BIT_SEC_OT) | ({7'h00, sec_uv_evt} << BIT_SEC_UV)
      | ({7'h00, short_long & main_gate} << BIT_MAIN_SC)
      | ({7'h00, main_failsafe_evt} << BIT_MAIN_FS)
      | ({7'h00, main_uv_evt & uv_ok} << BIT_MAIN_UV);
   // clears act on the whole byte, limited to defined bits
   assign clr_b = (frame_done & cmd_clear & (cmd_addr == ADDR_STAT_B))
      ? STAT_B_MASK : 8'h00;
   assign clr_a = (frame_done & cmd_clear & (cmd_addr == ADDR_STAT_A))
      ? STAT_A_MASK : 8'h00;
   assign keep_b = restart ? STAT_B_RESTART_KEEP : 8'hff;
   assign keep_a = restart ? STAT_A_RESTART_KEEP : 8'hff;
   assign rst_a = STAT_A_SOFT;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_flags
         sticky_flag u_a
         (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .rst_val(rst_a[gi]),
            .load(load_rst | ~keep_a[gi]),
            .set(set_a[gi] & ~load_rst),
            .clr(clr_a[gi]),
            .q(stat_a[gi])
         );
         sticky_flag u_b
         (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .rst_val(STAT_B_RST[gi]),
            .load(load_rst | ~keep_b[gi] | ~STAT_B_MASK[gi]),
            .set(set_b[gi] & STAT_B_MASK[gi] & ~load_rst),
            .clr(clr_b[gi]),
            .q(stat_b[gi])
         );
      end
   endgenerate
   assign rd_byte = (cmd_addr == ADDR_UPPER) ? recovery_upper_bound
      : (cmd_addr == ADDR_LOWER) ? recovery_lower_bound
      : (cmd_addr == ADDR_STAT_B) ? (stat_b & STAT_B_MASK)
      : (cmd_addr == ADDR_STAT_A) ? stat_a : 8'h00;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shift_reg <= 16'h0000;
         hdr_reg <= 8'h00;
         cnt_reg <= 5'd0;
         sck_d_reg <= 1'b0;
         miso_reg <= 1'b0;
      end
      else
      begin
         sck_d_reg <= link.sck;
         if (link.cs_n)
            cnt_reg <= 5'd0;
         else if (sck_rise)
         begin
            shift_reg <= {shift_reg[14:0], link.mosi};
            cnt_reg <= cnt_reg + 5'd1;
            if (cnt_reg == 5'd7)
               hdr_reg <= {link.mosi, shift_reg[0], shift_reg[1], shift_reg[2], shift_reg[3],
                  shift_reg[4], shift_reg[5], shift_reg[6]};
         end
         // after the address byte, read data goes out D0 first
         if (link.cs_n)
            miso_reg <= 1'b0;
         else if (sck_fall & (cnt_reg >= 5'd8) & (cnt_reg < 5'd16))
            miso_reg <= rd_byte[3'(cnt_reg - 5'd8)];
      end
   end
   assign link.miso = miso_reg;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         recovery_upper_bound <= UPPER_RST;
         recovery_lower_bound <= LOWER_RST;
         por_pend_reg <= 1'b1;
         ro_seen_reg <= 1'b0;
         sc_cnt_reg <= 23'd0;
         bit_time_clamped <= 8'h00;
      end
      else
      begin
         por_pend_reg <= 1'b0;
         if (soft_reset)
         begin
            recovery_upper_bound <= UPPER_RST;
            recovery_lower_bound <= LOWER_RST;
         end
         else if (frame_done & ~cmd_clear)
         begin
            // the register write happens at end of frame
            if (cmd_addr == ADDR_UPPER)
               recovery_upper_bound <= cmd_data;
            if (cmd_addr == ADDR_LOWER)
               recovery_lower_bound <= cmd_data;
         end
         if (dev_mode != MODE_INIT)
            ro_seen_reg <= 1'b0;
         else if (reset_output_pin)
            ro_seen_reg <= 1'b1;
         if (!main_below_rst)
            sc_cnt_reg <= 23'd0;
         else if (!short_long)
            sc_cnt_reg <= sc_cnt_reg + 23'd1;
         if (bit_time_setting > recovery_upper_bound)
            bit_time_clamped <= recovery_upper_bound;
         else if (bit_time_setting < recovery_lower_bound)
            bit_time_clamped <= recovery_lower_bound;
         else
            bit_time_clamped <= bit_time_setting;
      end
   end
endmodule
`default_nettype wire

// file: sim/supply_status_props.sv
// wire checks for the serial command link
// assumes host and device ends joined by serial_cmd_if
`timescale 1ns/1ps
`default_nettype none
module supply_status_props
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   logic [5:0] rise_cnt;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   sequence high_half;
      sck[*4] ##1 !sck;
   endsequence
   sequence frame_end;
      ##[120:200] $rose(cs_n);
   endsequence
   // counts sck rises inside one frame
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         rise_cnt <= 6'h00;
      else if (cs_n)
         rise_cnt <= 6'h00;
      else if ($rose(sck))
         rise_cnt <= rise_cnt + 6'h01;
   end
   frame_len_a: assert property ($rose(cs_n) |-> rise_cnt == 6'h10)
      else $error("frame does not hold 16 clocks");
   idle_clock_a: assert property (cs_n |-> !sck)
      else $error("sck moves outside a frame");
   high_half_a: assert property ($rose(sck) |-> high_half)
      else $error("sck high phase not 4 cycles");
   low_half_a: assert property ($fell(sck) |-> !sck [*4])
      else $error("sck low phase under 4 cycles");
   mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
      else $error("mosi moved while sck high");
   miso_hold_a: assert property (sck && $past(sck) |-> $stable(miso))
      else $error("miso moved while sck high");
   frame_time_a: assert property ($fell(cs_n) |-> frame_end)
      else $error("frame did not end in time");
   cs_gap_a: assert property ($rose(cs_n) |=> cs_n)
      else $error("no idle gap between frames");
endmodule
`default_nettype wire

// file: sim/supply_status_spi_regs_tb.sv
// testbench: avalon orders through host end to register bank
// assumes package constants and serial_cmd_if from rtl
`timescale 1ns/1ps
`default_nettype none
module supply_status_spi_regs_tb
   import supply_regs_pkg::*;
;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] avs_address = 16'h0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic soft_reset = 1'b0;
   dev_mode_e dev_mode = MODE_NORMAL;
   logic main_reg_off = 1'b0;
   logic reset_output_pin = 1'b0;
   logic below_rst = 1'b0;
   logic [8:0] ev = 9'h000;
   logic [7:0] bts = 8'ha0;
   logic [7:0] clamped, up_b, lo_b;
   logic [31:0] rdw;
   int tests_run = 0;
   int bad_count = 0;
   int cyc = 0;
   localparam logic [6:0] EAD[9] = '{7'h40, 7'h40, 7'h40, 7'h41, 7'h41, 7'h41, 7'h41, 7'h41,
      7'h41};
   localparam logic [7:0] EXP[9] = '{8'h40, 8'h02, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02,
      8'h01};
   localparam logic [7:0] BTS[3] = '{8'hb1, 8'h8f, 8'ha0};
   localparam logic [7:0] CLP[3] = '{8'hb0, 8'h90, 8'ha0};
   serial_cmd_if link();
   supply_host_ctrl u_supply_host_ctrl
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link.host)
   );
   supply_status_spi_regs u_supply_status_spi_regs
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .link(link.dev), .soft_reset(soft_reset),
      .dev_mode(dev_mode), .main_reg_off(main_reg_off), .reset_output_pin(reset_output_pin),
      .batt_uv_evt(ev[0]), .main_ov_evt(ev[1]), .main_pw_evt(ev[2]), .sw_uv_evt(ev[3]),
      .sw_ov_evt(ev[4]), .sec_ot_evt(ev[5]), .sec_uv_evt(ev[6]), .main_below_rst(below_rst),
      .main_failsafe_evt(ev[7]), .main_uv_evt(ev[8]), .bit_time_setting(bts),
      .bit_time_clamped(clamped), .recovery_upper_bound(up_b), .recovery_lower_bound(lo_b)
   );
   supply_status_props u_supply_status_props
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .sck(link.sck), .cs_n(link.cs_n),
      .mosi(link.mosi), .miso(link.miso)
   );
   always #10 clk_sys = ~clk_sys;
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic [15:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      rdw = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rc(input logic [6:0] a, input logic c, input logic [7:0] d,
      input logic [7:0] e);
      bus(AV_CTRL, 1'b1, {16'h0000, d, c, a});
      rdw = 32'h1;
      while (rdw[0] !== 1'b0)
         bus(AV_STAT, 1'b0, 32'h0);
      chk("done", 8'h01, {7'h00, rdw[1]});
      bus(AV_RDATA, 1'b0, 32'h0);
      chk($sformatf("reg_%h", a), e, rdw[7:0]);
   endtask
   task automatic pulse(input logic [8:0] m);
      @(posedge clk_sys);
      ev <= m;
      @(posedge clk_sys);
      ev <= 9'h000;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         test_done();
      end
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      rc(ADDR_STAT_A, 1'b1, 8'h00, STAT_A_POR);
      rc(ADDR_STAT_A, 1'b0, 8'h00, 8'h00);
      rc(ADDR_UPPER, 1'b0, 8'hb0, UPPER_RST);
      rc(ADDR_LOWER, 1'b0, 8'h90, LOWER_RST);
      rc(ADDR_UPPER, 1'b1, 8'h00, 8'hb0);
      chk("upper_bound", 8'hb0, up_b);
      chk("lower_bound", 8'h90, lo_b);
      for (int i = 0; i < 3; i++)
      begin
         bts <= BTS[i];
         repeat (3) @(posedge clk_sys);
         chk("clamped", CLP[i], clamped);
      end
      for (int i = 0; i < 9; i++)
      begin
         pulse(9'h001 << i);
         rc(EAD[i], 1'b0, 8'h00, EXP[i]);
         rc(EAD[i], 1'b0, 8'h00, EXP[i]);
         rc(EAD[i], 1'b1, 8'h00, EXP[i]);
         rc(EAD[i], 1'b0, 8'h00, 8'h00);
      end
      pulse(9'h007);
      rc(ADDR_STAT_B, 1'b1, 8'h00, STAT_B_MASK);
      bus(16'h0010, 1'b0, 32'h0);
      chk("unmapped", 8'h00, {7'h00, |rdw});
      dev_mode <= MODE_SLEEP;
      main_reg_off <= 1'b1;
      pulse(9'h102);
      rc(ADDR_STAT_B, 1'b0, 8'h00, 8'h00);
      rc(ADDR_STAT_A, 1'b0, 8'h00, 8'h00);
      dev_mode <= MODE_INIT;
      main_reg_off <= 1'b0;
      pulse(9'h100);
      rc(ADDR_STAT_A, 1'b0, 8'h00, 8'h00);
      reset_output_pin <= 1'b1;
      pulse(9'h100);
      rc(ADDR_STAT_A, 1'b1, 8'h00, 8'h01);
      dev_mode <= MODE_RESTART;
      pulse(9'h100);
      rc(ADDR_STAT_A, 1'b0, 8'h00, 8'h00);
      dev_mode <= MODE_NORMAL;
      pulse(9'h0c3);
      dev_mode <= MODE_RESTART;
      repeat (4) @(posedge clk_sys);
      dev_mode <= MODE_NORMAL;
      rc(ADDR_STAT_B, 1'b1, 8'h00, 8'h42);
      rc(ADDR_STAT_A, 1'b1, 8'h00, 8'h08);
      pulse(9'h008);
      soft_reset <= 1'b1;
      @(posedge clk_sys);
      soft_reset <= 1'b0;
      rc(ADDR_STAT_A, 1'b0, 8'h00, STAT_A_SOFT);
      rc(ADDR_UPPER, 1'b0, UPPER_RST, UPPER_RST);
      below_rst <= 1'b1;
      repeat (1000) @(posedge clk_sys);
      below_rst <= 1'b0;
      rc(ADDR_STAT_A, 1'b0, 8'h00, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
